//--- rtl/icr_port.sv
// Purpose: ISA command strobes, upper address and channel-ready pin control
// Assumes: ownership, target decode and data-ready come from the bridge core
// Notes: pins are split into in, out and output enable; enable high drives
`timescale 1ns/1ns
module icr_port
  import icr_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire logic            suspend_in,
  input  wire icr_owner_t      owner_in,
  input  wire logic            ext_hits_us_in,
  input  wire logic            ext_data_done_in,
  input  wire icr_cmd_t        cmd_in,
  input  wire logic            extended_io_bus_option_in,
  input  wire logic [UA_W-1:0] general_output_pins_in,
  input  wire logic            ior_b_in,
  input  wire logic            iow_b_in,
  input  wire logic            chrdy_in,
  input  wire logic            io16_b_in,
  input  wire logic [UA_W-1:0] ua_in,
  output logic                 ior_b_out,
  output logic                 ior_oe_out,
  output logic                 iow_b_out,
  output logic                 iow_oe_out,
  output logic                 chrdy_out,
  output logic                 chrdy_oe_out,
  output logic      [UA_W-1:0] ua_out,
  output logic                 ua_oe_out,
  output logic                 slave_ready_out,
  output logic                 io16_sel_out,
  output logic                 ext_rd_out,
  output logic                 ext_wr_out,
  output logic      [UA_W-1:0] ext_ua_out
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  icr_pins_t pins_raw;
  icr_pins_t pins;

  assign pins_raw = '{ior_b: ior_b_in, iow_b: iow_b_in, chrdy: chrdy_in,
                      io16_b: io16_b_in, ua: ua_in};

  icr_sync #(.W($bits(icr_pins_t))) u_sync (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .d_in       (pins_raw),
    .rst_val_in ('1),
    .q_out      (pins)
  );

  // ------------------------------------------------------------
  // ownership direction
  // ------------------------------------------------------------
  logic we_own;
  logic out_live;
  logic cmd_prev;
  logic cmd_now;
  logic cmd_fall;

  assign we_own = (owner_in != ICR_OWN_EXT);

  // first clock after reset release, strobes stay floating until then
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      out_live <= 1'b0;
    else
      out_live <= 1'b1;
  end

  // strobes, and address outside option mode, share we_own in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ior_oe_out <= 1'b0;
      iow_oe_out <= 1'b0;
      ior_b_out  <= 1'b1;
      iow_b_out  <= 1'b1;
    end
    else
    begin
      ior_oe_out <= we_own;
      iow_oe_out <= we_own;
      ior_b_out  <= ~(we_own & cmd_in.ior & ~suspend_in);
      iow_b_out  <= ~(we_own & cmd_in.iow & ~suspend_in);
    end
  end

  // upper address; in option mode pins become general outputs, always driven
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ua_oe_out <= 1'b0;
      ua_out    <= UA_RESET;
    end
    else if (extended_io_bus_option_in)
    begin
      ua_oe_out <= 1'b1;
      ua_out    <= general_output_pins_in;
    end
    else
    begin
      ua_oe_out <= we_own;
      if (we_own && !suspend_in)
        ua_out <= cmd_in.ua;
    end
  end

  // ------------------------------------------------------------
  // external master command sense
  // ------------------------------------------------------------
  assign cmd_now = ~pins.ior_b | ~pins.iow_b;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cmd_prev <= 1'b0;
    else
      cmd_prev <= cmd_now;
  end

  assign cmd_fall = cmd_now & ~cmd_prev & ~we_own;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_rd_out   <= 1'b0;
      ext_wr_out   <= 1'b0;
      ext_ua_out   <= UA_RESET;
      io16_sel_out <= 1'b0;
      slave_ready_out <= 1'b1;
    end
    else
    begin
      ext_rd_out   <= ~we_own & ~pins.ior_b & ext_hits_us_in;
      ext_wr_out   <= ~we_own & ~pins.iow_b & ext_hits_us_in;
      ext_ua_out   <= ~we_own ? pins.ua : ext_ua_out;
      io16_sel_out <= ~pins.io16_b;
      slave_ready_out <= pins.chrdy;
    end
  end

  // ------------------------------------------------------------
  // channel-ready driver
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RDY_FLOAT,
    RDY_HOLD_LOW,
    RDY_PULSE
  } icr_rdy_t;

  icr_rdy_t             rdy_st;
  logic [RDY_CNT_W-1:0] rdy_cnt;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdy_st  <= RDY_FLOAT;
      rdy_cnt <= RDY_CNT_ZERO;
    end
    else if (suspend_in || we_own)
    begin
      rdy_st  <= RDY_FLOAT;
      rdy_cnt <= RDY_CNT_ZERO;
    end
    else
    begin
      case (rdy_st)
        RDY_FLOAT:
          if (cmd_fall && ext_hits_us_in)
            rdy_st <= RDY_HOLD_LOW;
        RDY_HOLD_LOW:
          if (ext_data_done_in)
          begin
            rdy_st  <= RDY_PULSE;
            rdy_cnt <= RDY_CNT_LOAD;
          end
        RDY_PULSE:
          if (rdy_cnt == RDY_CNT_ONE)
          begin
            rdy_st  <= RDY_FLOAT;
            rdy_cnt <= RDY_CNT_ZERO;
          end
          else
            rdy_cnt <= rdy_cnt - RDY_CNT_ONE;
        default:
          rdy_st <= RDY_FLOAT;
      endcase
    end
  end

  assign chrdy_oe_out = (rdy_st != RDY_FLOAT);
  assign chrdy_out    = (rdy_st == RDY_PULSE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_pulse_start;
    (rdy_st == RDY_HOLD_LOW) && !suspend_in && !we_own && ext_data_done_in;
  endsequence

  chk_rdy_pulse_len: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_pulse_start |=> (chrdy_oe_out && chrdy_out) [*3] ##1 !chrdy_oe_out)
    else $error("ready pulse length wrong");

  chk_rdy_low_cmd: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rdy_st == RDY_FLOAT && cmd_fall && ext_hits_us_in && !suspend_in)
      |=> chrdy_oe_out && !chrdy_out)
    else $error("ready not driven low at command");

  chk_rdy_float_own: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    we_own |=> !chrdy_oe_out)
    else $error("ready driven while we own the bus");

  chk_rdy_other_slave: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rdy_st == RDY_FLOAT && !ext_hits_us_in) |=> !chrdy_oe_out)
    else $error("ready driven for another slave");

  chk_rdy_suspend: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    suspend_in |=> !chrdy_oe_out)
    else $error("ready driven in suspend");

  chk_strobe_dir: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    out_live |-> (ior_oe_out == $past(we_own)) && (iow_oe_out == ior_oe_out))
    else $error("strobe directions disagree");

  chk_strobe_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $past(suspend_in) && out_live |-> ior_b_out && iow_b_out)
    else $error("strobes not high in suspend");

  chk_ua_dir: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    out_live && !$past(extended_io_bus_option_in) |-> ua_oe_out == $past(we_own))
    else $error("upper address direction wrong");

  chk_gpo_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    extended_io_bus_option_in |=> ua_oe_out && ua_out == $past(general_output_pins_in))
    else $error("general outputs not driven");

endmodule : icr_port

//--- rtl/icr_pkg.sv
// Purpose: constants and carrier types for the ISA command and ready port
// Assumes: 50 MHz core clock, one clock domain
// Notes: all two-way pins are split into in, out and output enable
package icr_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned RDY_PULSE_NS   = 70;
  // longest time rounds down so the release finishes inside the budget
  localparam int unsigned RDY_PULSE_CYC  = (RDY_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                           (RDY_PULSE_NS / CLK_PERIOD_NS);
  localparam int unsigned RDY_CNT_W      = 3;
  localparam logic [RDY_CNT_W-1:0] RDY_CNT_LOAD = RDY_CNT_W'(RDY_PULSE_CYC);
  localparam logic [RDY_CNT_W-1:0] RDY_CNT_ZERO = 3'h0;
  localparam logic [RDY_CNT_W-1:0] RDY_CNT_ONE  = 3'h1;

  // ------------------------------------------------------------
  // upper address
  // ------------------------------------------------------------
  localparam int unsigned UA_LSB = 17;
  localparam int unsigned UA_MSB = 23;
  localparam int unsigned UA_W   = UA_MSB - UA_LSB + 1;
  localparam logic [UA_W-1:0] UA_RESET = 7'h00;

  typedef enum logic [1:0] {
    ICR_OWN_BRIDGE,
    ICR_OWN_DMA,
    ICR_OWN_EXT
  } icr_owner_t;

  // synchronised view of the ISA pins
  typedef struct packed {
    logic            ior_b;
    logic            iow_b;
    logic            chrdy;
    logic            io16_b;
    logic [UA_W-1:0] ua;
  } icr_pins_t;

  // core request when the bridge masters the bus
  typedef struct packed {
    logic            ior;
    logic            iow;
    logic [UA_W-1:0] ua;
  } icr_cmd_t;

endpackage : icr_pkg

//--- rtl/icr_sync.sv
// Purpose: two-flop synchroniser for a packed group of pin levels
// Assumes: inputs are asynchronous levels
// Notes: stage one is read only by stage two
`timescale 1ns/1ns
module icr_sync
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stage1 <= '1;
      q_out  <= '1;
    end
    else
    begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end

  // rst_val_in kept for interface symmetry; idle level of all pins is high
  logic unused_rst;
  assign unused_rst = &rst_val_in;
endmodule : icr_sync

//--- sim/icr_far_model.sv
// Purpose: far side of the ISA port: external master, wait-state slave
// Assumes: pulled-up lines resolve high in the bench when released
// Notes: registered outputs, so every change follows a clock edge
`timescale 1ns/1ns
module icr_far_model
  import icr_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic [1:0]      cmd_in,
  input  wire logic            wait_in,
  input  wire logic            wide_in,
  input  wire logic [UA_W-1:0] addr_in,
  input  wire logic            bus_ior_b_in,
  input  wire logic            bus_iow_b_in,
  input  wire logic [UA_W-1:0] bus_ua_in,
  output logic                 ior_b_out,
  output logic                 iow_b_out,
  output logic                 strobe_oe_out,
  output logic                 chrdy_pull_out,
  output logic                 io16_b_out,
  output logic      [UA_W-1:0] ua_out,
  output logic                 rd_drive_out,
  output logic                 wr_seen_out,
  output logic      [UA_W-1:0] ua_latch_out
);
  logic ior_low_d;

  initial
  begin
    ior_low_d      = 1'b0;
    rd_drive_out   = 1'b0;
    wr_seen_out    = 1'b0;
    ua_latch_out   = 7'h00;
    ior_b_out      = 1'b1;
    iow_b_out      = 1'b1;
    strobe_oe_out  = 1'b0;
    chrdy_pull_out = 1'b0;
    io16_b_out     = 1'b1;
    ua_out         = 7'h00;
  end
  always @(posedge clk_in)
  begin
    strobe_oe_out  <= |cmd_in;
    ior_b_out      <= ~cmd_in[0];
    iow_b_out      <= ~cmd_in[1];
    chrdy_pull_out <= wait_in;
    io16_b_out     <= ~wide_in;
    // released address lines must not keep the last value
    ua_out         <= (|cmd_in) ? addr_in : ~ua_out;
    // slave side: answers a command that the port drives
    ior_low_d      <= ~bus_ior_b_in;
    rd_drive_out   <= ~bus_ior_b_in | ior_low_d;
    wr_seen_out    <= wr_seen_out | ~bus_iow_b_in;
    // no latch enable here; read command start stands in for its trailing edge
    if (~bus_ior_b_in & ~ior_low_d)
      ua_latch_out <= bus_ua_in;
  end
endmodule : icr_far_model

//--- sim/tb_isa_command_ready_port.sv
// Purpose: self-checking bench for the ISA command and ready port
// Assumes: 50 MHz clock, inputs driven 2 ns after the rising edge
// Notes: pin levels resolved here from every party's output enable
`timescale 1ns/1ns
module tb_isa_command_ready_port;
  import icr_pkg::*;
  logic clk_in, rst_b_in, suspend, hits, done, opt, wt, w16;
  logic ior_b, ior_oe, iow_b, iow_oe, chrdy, chrdy_oe, ua_oe, srdy, sel16, e_rd, e_wr;
  logic p_ior, p_iow, p_oe, p_pull, p_io16;
  logic [1:0] pcmd;
  logic [UA_W-1:0] gpo, ua_o, e_ua, p_ua, paddr;
  logic rd_drive, wr_seen;
  logic [UA_W-1:0] ua_latch;
  icr_owner_t owner;
  icr_cmd_t cmd;
  int bad_count, total_checks;
  wire ior_w = ior_oe ? ior_b : (p_oe ? p_ior : 1'b1);
  wire iow_w = iow_oe ? iow_b : (p_oe ? p_iow : 1'b1);
  wire chrdy_w = chrdy_oe ? chrdy : ~p_pull;
  wire [UA_W-1:0] ua_w = ua_oe ? ua_o : p_ua;

  icr_port u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .suspend_in(suspend),
    .owner_in(owner), .ext_hits_us_in(hits), .ext_data_done_in(done), .cmd_in(cmd),
    .extended_io_bus_option_in(opt), .general_output_pins_in(gpo), .ior_b_in(ior_w),
    .iow_b_in(iow_w), .chrdy_in(chrdy_w), .io16_b_in(p_io16), .ua_in(ua_w),
    .ior_b_out(ior_b), .ior_oe_out(ior_oe), .iow_b_out(iow_b), .iow_oe_out(iow_oe),
    .chrdy_out(chrdy), .chrdy_oe_out(chrdy_oe), .ua_out(ua_o), .ua_oe_out(ua_oe),
    .slave_ready_out(srdy), .io16_sel_out(sel16), .ext_rd_out(e_rd),
    .ext_wr_out(e_wr), .ext_ua_out(e_ua));
  icr_far_model u_far (.clk_in(clk_in), .cmd_in(pcmd), .wait_in(wt), .wide_in(w16),
    .addr_in(paddr), .bus_ior_b_in(ior_w), .bus_iow_b_in(iow_w), .bus_ua_in(ua_w),
    .ior_b_out(p_ior), .iow_b_out(p_iow), .strobe_oe_out(p_oe),
    .chrdy_pull_out(p_pull), .io16_b_out(p_io16), .ua_out(p_ua),
    .rd_drive_out(rd_drive), .wr_seen_out(wr_seen), .ua_latch_out(ua_latch));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : step

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for the ready driver to switch
  task automatic wait_oe(input logic v);
    int i;
    for (i = 0; i < 8 && chrdy_oe !== v; i++)
      step();
    if (i == 8)
    begin
      bad_count++;
      summarize();
    end
  endtask : wait_oe

  task automatic t_bridge();
    cmd = {1'b1, 1'b0, 7'h5A};
    step();
    chk({ior_oe, ior_b, iow_oe, iow_b, ua_oe}, 5'b10111);
    chk(ua_o, 7'h5A);
    cmd = {1'b0, 1'b1, 7'h21};
    step();
    chk({ior_b, iow_b}, 2'b10);
    chk({rd_drive, wr_seen}, 2'b10);
    owner = ICR_OWN_EXT;
    cmd = '0;
    step();
    chk({ior_oe, iow_oe, ua_oe}, 3'b000);
    chk({rd_drive, wr_seen}, 2'b11);
    chk(ua_latch, 7'h5A);
    // our last strobes must clear the synchroniser before a master starts
    step(4);
  endtask : t_bridge

  task automatic t_ext(input logic [1:0] k);
    hits = 1'b1;
    paddr = 7'h3C;
    pcmd = k;
    wait_oe(1'b1);
    chk({chrdy_oe, chrdy}, 2'b10);
    chk({e_rd, e_wr, ior_oe, iow_oe}, {k[0], k[1], 2'b00});
    chk(e_ua, 7'h3C);
    step(2);
    chk({chrdy_oe, chrdy}, 2'b10);
    done = 1'b1;
    step();
    done = 1'b0;
    repeat (3)
    begin
      chk({chrdy_oe, chrdy}, 2'b11);
      step();
    end
    chk(chrdy_oe, 1'b0);
    pcmd = 2'b00;
    step(4);
  endtask : t_ext

  task automatic t_other();
    hits = 1'b0;
    pcmd = 2'b01;
    repeat (6)
    begin
      step();
      chk(chrdy_oe, 1'b0);
    end
    pcmd = 2'b00;
    step(4);
  endtask : t_other

  task automatic t_suspend();
    hits = 1'b1;
    pcmd = 2'b10;
    wait_oe(1'b1);
    suspend = 1'b1;
    step();
    chk({chrdy_oe, ior_b, iow_b}, 3'b011);
    pcmd = 2'b00;
    step(4);
    owner = ICR_OWN_BRIDGE;
    cmd = {1'b1, 1'b1, 7'h00};
    step();
    chk({ior_oe, ior_b, iow_oe, iow_b}, 4'hF);
    cmd = '0;
    suspend = 1'b0;
    step();
  endtask : t_suspend

  task automatic t_reset();
    owner = ICR_OWN_EXT;
    hits = 1'b1;
    pcmd = 2'b01;
    wait_oe(1'b1);
    rst_b_in = 1'b0;
    step();
    chk({chrdy_oe, ior_oe, iow_oe, ua_oe}, 4'h0);
    pcmd = 2'b00;
    step(3);
    rst_b_in = 1'b1;
    step(2);
    chk({chrdy_oe, ior_oe, iow_oe, ior_b, iow_b}, 5'b00011);
  endtask : t_reset

  task automatic t_wait();
    hits = 1'b0;
    owner = ICR_OWN_DMA;
    cmd = {1'b1, 1'b0, 7'h11};
    wt = 1'b1;
    w16 = 1'b1;
    step(4);
    chk({srdy, chrdy_oe, sel16}, 3'b001);
    wt = 1'b0;
    w16 = 1'b0;
    step(4);
    chk({srdy, sel16}, 2'b10);
    cmd = '0;
    opt = 1'b1;
    gpo = 7'h2B;
    owner = ICR_OWN_EXT;
    step(2);
    chk({ua_oe, ua_o}, {1'b1, 7'h2B});
  endtask : t_wait

  initial
  begin
    rst_b_in = 1'b0;
    {suspend, hits, done, opt, wt, w16} = '0;
    owner = ICR_OWN_BRIDGE;
    cmd = '0;
    gpo = 7'h00;
    paddr = 7'h00;
    pcmd = 2'b00;
    step(3);
    chk({ior_oe, iow_oe, ua_oe, chrdy_oe}, 4'h0);
    step();
    rst_b_in = 1'b1;
    step(2);
    chk({ior_oe, ior_b, iow_oe, iow_b, chrdy_oe}, 5'b11110);
    t_bridge();
    t_ext(2'b01);
    t_ext(2'b10);
    t_other();
    t_suspend();
    t_reset();
    t_wait();
    summarize();
  end
endmodule : tb_isa_command_ready_port
